// ### rtl/swd_key_step.sv
// next-key generator for keyed servicing
module swd_key_step
  import swd_pkg::*;
(
  input wire logic [15:0] key_now,
  output logic [15:0] key_next
);
  import swd_pkg::*;
  logic [31:0] prod;
  // 17 * (k + 3), kept to the low 16 bits
  always_comb
  begin
    prod = 32'({16'h0000, 16'(key_now + SWD_KEY_ADD)} * {16'h0000, SWD_KEY_MUL});
    key_next = prod[15:0];
  end
endmodule

// ### rtl/swd_pkg.sv
// shared constants and types for the software watchdog
package swd_pkg;
  // register offsets (byte addresses, one 32-bit word each)
  localparam logic [7:0] SWD_CTRL_OFS = 8'h00;
  localparam logic [7:0] SWD_TIMEOUT_OFS = 8'h04;
  localparam logic [7:0] SWD_WINDOW_OFS = 8'h08;
  localparam logic [7:0] SWD_SERVICE_OFS = 8'h0c;
  localparam logic [7:0] SWD_COUNT_OFS = 8'h10;
  localparam logic [7:0] SWD_KEY_OFS = 8'h14;
  localparam logic [7:0] SWD_STATUS_OFS = 8'h18;
  localparam logic [7:0] SWD_INT_EN_OFS = 8'h1c;
  localparam logic [7:0] SWD_INT_CLR_OFS = 8'h20;
  // control register bit positions
  localparam int SWD_CTRL_EN_BIT = 0;
  localparam int SWD_CTRL_LOCK_BIT = 1;
  localparam int SWD_CTRL_IRQ_FIRST_BIT = 2;
  localparam int SWD_CTRL_WIN_BIT = 3;
  localparam int SWD_CTRL_KEYED_BIT = 4;
  localparam int SWD_CTRL_W = 5;
  // status bit positions
  localparam int SWD_ST_TIMEOUT_BIT = 0;
  localparam int SWD_ST_FAULT_BIT = 1;
  localparam int SWD_ST_BADSVC_BIT = 2;
  localparam int SWD_ST_W = 3;
  // service words and key arithmetic
  localparam logic [15:0] SWD_SVC_WORD_A = 16'ha602;
  localparam logic [15:0] SWD_SVC_WORD_B = 16'hb480;
  localparam logic [15:0] SWD_KEY_ADD = 16'h0003;
  localparam logic [15:0] SWD_KEY_MUL = 16'h0011;
  localparam logic [15:0] SWD_KEY_RESET = 16'h0000;
  // reset values
  localparam logic [31:0] SWD_TIMEOUT_RESET = 32'h0000_0100;
  localparam logic [31:0] SWD_WINDOW_RESET = 32'h0000_0000;
  localparam logic [SWD_CTRL_W-1:0] SWD_CTRL_RESET = 5'h00;
  // service sequence states, gray along the path
  typedef enum logic [1:0]
  {
    SWD_SVC_IDLE = 2'b00,
    SWD_SVC_HALF = 2'b01
  } swd_svc_state_t;
endpackage

// ### rtl/swd_watchdog.sv
// software watchdog: windowed, keyed, two-stage timeout to the fault collector
module swd_watchdog
  import swd_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  output logic fault_collector
);
  import swd_pkg::*;

  // ****************************************
  // register state
  // ****************************************
  logic [SWD_CTRL_W-1:0] ctrl_r;
  logic [31:0] timeout_r;
  logic [31:0] window_r;
  logic [31:0] count_r;
  logic [15:0] key_r;
  logic [15:0] key_nxt;
  logic [SWD_ST_W-1:0] status_r;
  logic [SWD_ST_W-1:0] int_en_r;
  logic [31:0] rdata_r;
  logic fault_r;
  logic armed_r;
  swd_svc_state_t svc_r;

  logic enabled;
  logic hard_lock_flag;
  logic irq_first;
  logic win_mode;
  logic keyed_mode;
  logic svc_wr;
  logic in_window;
  logic svc_ok;
  logic svc_bad;
  logic expire;
  logic cfg_wr_ok;

  assign enabled = ctrl_r[SWD_CTRL_EN_BIT];
  assign hard_lock_flag = ctrl_r[SWD_CTRL_LOCK_BIT];
  assign irq_first = ctrl_r[SWD_CTRL_IRQ_FIRST_BIT];
  assign win_mode = ctrl_r[SWD_CTRL_WIN_BIT];
  assign keyed_mode = ctrl_r[SWD_CTRL_KEYED_BIT];
  assign svc_wr = reg_wr && (reg_addr == SWD_SERVICE_OFS) && enabled;
  assign cfg_wr_ok = reg_wr && !hard_lock_flag;

  // ****************************************
  // service check
  // ****************************************
  swd_key_step u_key_step
  (
    .key_now(key_r),
    .key_next(key_nxt)
  );

  // window: service allowed only once the counter has dropped to the window value
  // an early service is a bad service: it sets the status bit and does not reload
  // window gate
  assign in_window = !win_mode || (count_r <= window_r);

  always_comb
  begin
    svc_ok = 1'b0;
    svc_bad = 1'b0;
    if (svc_wr)
    begin
      if (!in_window)
      begin
        svc_bad = 1'b1;
      end
      else if (keyed_mode)
      begin
        svc_ok = (reg_wdata[15:0] == key_r);
        svc_bad = (reg_wdata[15:0] != key_r);
      end
      else
      begin
        case (svc_r)
          SWD_SVC_IDLE:
          begin
            svc_bad = (reg_wdata[15:0] != SWD_SVC_WORD_A);
          end
          SWD_SVC_HALF:
          begin
            svc_ok = (reg_wdata[15:0] == SWD_SVC_WORD_B);
            svc_bad = (reg_wdata[15:0] != SWD_SVC_WORD_B);
          end
          default:
          begin
            svc_bad = 1'b1;
          end
        endcase
      end
    end
  end

  // fixed-sequence tracker
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      svc_r <= SWD_SVC_IDLE;
    end
    else if (!enabled || keyed_mode)
    begin
      // a half-done pair must not survive a disable or a switch to keyed mode
      svc_r <= SWD_SVC_IDLE;
    end
    else if (svc_wr)
    begin
      if (svc_r == SWD_SVC_IDLE && in_window && reg_wdata[15:0] == SWD_SVC_WORD_A)
      begin
        svc_r <= SWD_SVC_HALF;
      end
      else
      begin
        svc_r <= SWD_SVC_IDLE;
      end
    end
  end

  // key advances on every valid keyed service
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      key_r <= SWD_KEY_RESET;
    end
    else if (svc_ok && keyed_mode)
    begin
      key_r <= key_nxt;
    end
  end

  // ****************************************
  // down-counter
  // ****************************************
  // core_clk is fed from the internal fast rc clock at chip level, so the count
  // never follows the system clock selection
  // a zero timeout expires on every cycle once enabled, so software must not program it
  assign expire = enabled && (count_r == 32'h0000_0000);

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      count_r <= SWD_TIMEOUT_RESET;
    end
    else if (!enabled || svc_ok || expire)
    begin
      count_r <= timeout_r;
    end
    else
    begin
      count_r <= count_r - 32'h0000_0001;
    end
  end

  // ****************************************
  // timeout handling
  // ****************************************
  // armed_r marks that a first timeout already raised the interrupt
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      armed_r <= 1'b0;
    end
    else if (!enabled || svc_ok)
    begin
      armed_r <= 1'b0;
    end
    else if (expire && irq_first)
    begin
      armed_r <= 1'b1;
    end
  end

  // fault stays asserted until reset: the collector owns the recovery
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      fault_r <= 1'b0;
    end
    else if (expire && !irq_first)
    begin
      fault_r <= 1'b1;
    end
    else if (expire && armed_r)
    begin
      fault_r <= 1'b1;
    end
  end
  assign fault_collector = fault_r;

  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      ctrl_r <= SWD_CTRL_RESET;
    end
    else if (cfg_wr_ok && reg_addr == SWD_CTRL_OFS)
    begin
      ctrl_r <= reg_wdata[SWD_CTRL_W-1:0];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      timeout_r <= SWD_TIMEOUT_RESET;
      window_r <= SWD_WINDOW_RESET;
    end
    else if (cfg_wr_ok && reg_addr == SWD_TIMEOUT_OFS)
    begin
      timeout_r <= reg_wdata;
    end
    else if (cfg_wr_ok && reg_addr == SWD_WINDOW_OFS)
    begin
      window_r <= reg_wdata;
    end
  end

  // ****************************************
  // interrupt status
  // ****************************************
  logic [SWD_ST_W-1:0] st_set;
  logic [SWD_ST_W-1:0] st_clr;

  // clearing the fault status bit does not release the fault line
  always_comb
  begin
    st_set = '0;
    st_set[SWD_ST_TIMEOUT_BIT] = expire && irq_first && !armed_r;
    st_set[SWD_ST_FAULT_BIT] = expire && (!irq_first || armed_r);
    st_set[SWD_ST_BADSVC_BIT] = svc_bad;
    st_clr = (reg_wr && reg_addr == SWD_INT_CLR_OFS) ? reg_wdata[SWD_ST_W-1:0] : '0;
  end

  // set beats clear in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      status_r <= '0;
    end
    else
    begin
      status_r <= (status_r & ~st_clr) | st_set;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      int_en_r <= '0;
    end
    else if (reg_wr && reg_addr == SWD_INT_EN_OFS)
    begin
      int_en_r <= reg_wdata[SWD_ST_W-1:0];
    end
  end

  assign irq = |(status_r & int_en_r);

  // ****************************************
  // read port
  // ****************************************
  logic [31:0] rdata_nxt;

  // write-only and unmapped words read as zero, and so does every cycle without a read
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    if (reg_rd)
    begin
      case (reg_addr)
        SWD_CTRL_OFS: rdata_nxt = 32'(ctrl_r);
        SWD_TIMEOUT_OFS: rdata_nxt = timeout_r;
        SWD_WINDOW_OFS: rdata_nxt = window_r;
        SWD_COUNT_OFS: rdata_nxt = count_r;
        SWD_KEY_OFS: rdata_nxt = {16'h0000, key_r};
        SWD_STATUS_OFS: rdata_nxt = 32'(status_r);
        SWD_INT_EN_OFS: rdata_nxt = 32'(int_en_r);
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end
  assign reg_rdata = rdata_r;
endmodule

// ### verification/swd_fault_sink.sv
// fault collector model: latches the watchdog fault line
module swd_fault_sink
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic fault_in,
  output logic fault_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge core_clk)
  begin
    if (!reset_n)
      fault_seen <= 1'b0;
    else if (fault_in)
      fault_seen <= 1'b1;
  end
endmodule

// ### verification/swd_watchdog_asserts.sv
// checker for the watchdog register port and fault outputs
module swd_watchdog_asserts
  import swd_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic irq,
  input wire logic fault_collector
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [SWD_CTRL_W-1:0] ctrl_r;
  logic [31:0] tmo_r;
  logic [SWD_ST_W-1:0] ien_r;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  // shadow copy; the lock freezes control and timeout
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      ctrl_r <= SWD_CTRL_RESET;
      tmo_r <= SWD_TIMEOUT_RESET;
      ien_r <= '0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == SWD_CTRL_OFS && !ctrl_r[SWD_CTRL_LOCK_BIT])
        ctrl_r <= reg_wdata[SWD_CTRL_W-1:0];
      if (reg_addr == SWD_TIMEOUT_OFS && !ctrl_r[SWD_CTRL_LOCK_BIT])
        tmo_r <= reg_wdata;
      if (reg_addr == SWD_INT_EN_OFS)
        ien_r <= reg_wdata[SWD_ST_W-1:0];
    end
  end
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  a_ctrl_read: assert property (reg_rd && reg_addr == SWD_CTRL_OFS |=> reg_rdata == {27'h0, $past(ctrl_r)})
    else $error("control readback wrong");
  a_timeout_read: assert property (reg_rd && reg_addr == SWD_TIMEOUT_OFS |=> reg_rdata == $past(tmo_r))
    else $error("timeout readback wrong");
  a_irq_masked: assert property (ien_r == '0 |-> !irq)
    else $error("irq while all sources masked");
  a_fault_sticky: assert property (fault_collector |=> fault_collector)
    else $error("fault dropped");
  a_fault_enabled: assert property ($rose(fault_collector) |-> $past(ctrl_r[SWD_CTRL_EN_BIT]))
    else $error("fault while disabled");
  a_service_wo: assert property (reg_rd && reg_addr == SWD_SERVICE_OFS |=> reg_rdata == 32'h0)
    else $error("service register readable");
  a_unmapped_zero: assert property (reg_rd && reg_addr > SWD_INT_CLR_OFS |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
endmodule
bind swd_watchdog swd_watchdog_asserts swd_watchdog_asserts_inst (.core_clk(core_clk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .irq(irq), .fault_collector(fault_collector));

// ### verification/tb_swd_watchdog.sv
// self-checking bench for the software watchdog
module tb_swd_watchdog;
  import swd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_q = 1'b0;
  logic [31:0] reg_rdata;
  logic irq;
  logic fault_collector;
  logic fault_seen;
  logic [33:0] exp_q[$];
  logic [33:0] exp_v;
  logic [31:0] rnd = 32'h0001_3084;
  logic [15:0] key;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  always #10 core_clk = ~core_clk;
  swd_watchdog swd_watchdog_inst (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .fault_collector(fault_collector));
  swd_fault_sink swd_fault_sink_inst (.core_clk(core_clk), .reset_n(reset_n), .fault_in(fault_collector),
    .fault_seen(fault_seen));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task end_of_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task rst();
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // expected note is {fault, irq, read data}
  task rd(input logic [7:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask
  // ****
  // monitor and hang guard
  // ****
  always @(posedge core_clk)
  begin
    rd_q <= reg_rd;
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_count++;
      end_of_test();
    end
  end
  always @(negedge core_clk)
  begin
    if (rd_q)
    begin
      exp_v = exp_q.pop_front();
      num_checks++;
      if ({fault_seen, irq, reg_rdata} !== exp_v)
      begin
        err_count++;
        $display("[ERR] t=%0t exp=%h got=%h", $time, exp_v, {fault_seen, irq, reg_rdata});
      end
    end
  end
  initial
  begin
    rst();
    rd(SWD_CTRL_OFS, 34'h0);
    rd(SWD_TIMEOUT_OFS, 34'h100);
    rd(SWD_KEY_OFS, 34'h0);
    rd(SWD_SERVICE_OFS, 34'h0);
    wr(SWD_TIMEOUT_OFS, 32'h40);
    wr(SWD_CTRL_OFS, 32'h1);
    // loaded on the enabling edge, one step down by the read edge
    rd(SWD_COUNT_OFS, 34'h3f);
    repeat (3)
    begin
      repeat (48) @(posedge core_clk);
      wr(SWD_SERVICE_OFS, 32'ha602);
      wr(SWD_SERVICE_OFS, 32'hb480);
    end
    rd(SWD_CTRL_OFS, 34'h1);
    wr(SWD_SERVICE_OFS, 32'ha602);
    wr(SWD_SERVICE_OFS, 32'h1234);
    wr(SWD_SERVICE_OFS, 32'hb480);
    repeat (80) @(posedge core_clk);
    rd(SWD_CTRL_OFS, {2'b10, 32'h1});
    rd(SWD_STATUS_OFS, {2'b10, 32'h6});
    rst();
    wr(SWD_INT_EN_OFS, 32'h1);
    wr(SWD_TIMEOUT_OFS, 32'h40);
    wr(SWD_CTRL_OFS, 32'h5);
    repeat (80) @(posedge core_clk);
    rd(SWD_STATUS_OFS, {2'b01, 32'h1});
    wr(SWD_INT_EN_OFS, 32'h0);
    rd(SWD_CTRL_OFS, 34'h5);
    wr(SWD_INT_EN_OFS, 32'h1);
    wr(SWD_INT_CLR_OFS, 32'h1);
    rd(SWD_STATUS_OFS, 34'h0);
    wr(SWD_INT_EN_OFS, 32'h0);
    repeat (50) @(posedge core_clk);
    rd(SWD_CTRL_OFS, {2'b10, 32'h5});
    rd(SWD_STATUS_OFS, {2'b10, 32'h2});
    rst();
    wr(SWD_TIMEOUT_OFS, 32'h40);
    wr(SWD_WINDOW_OFS, 32'h20);
    wr(SWD_CTRL_OFS, 32'h1b);
    rnd = lfsr(rnd);
    wr(SWD_CTRL_OFS, rnd);
    wr(SWD_TIMEOUT_OFS, rnd);
    wr(SWD_WINDOW_OFS, rnd);
    wr(8'h24, rnd);
    rd(8'h24, 34'h0);
    rd(SWD_CTRL_OFS, 34'h1b);
    rd(SWD_TIMEOUT_OFS, 34'h40);
    rd(SWD_WINDOW_OFS, 34'h20);
    key = 16'h0;
    // right key but before the window opens: refused, the key must not move
    wr(SWD_SERVICE_OFS, {16'h0, key});
    repeat (4)
    begin
      repeat (34) @(posedge core_clk);
      wr(SWD_SERVICE_OFS, {16'h0, key ^ 16'h1});
      rd(SWD_KEY_OFS, {18'h0, key});
      wr(SWD_SERVICE_OFS, {16'h0, key});
      key = (key + 16'h3) * 16'h11;
      rd(SWD_KEY_OFS, {18'h0, key});
    end
    repeat (80) @(posedge core_clk);
    rd(SWD_CTRL_OFS, {2'b10, 32'h1b});
    rd(SWD_STATUS_OFS, {2'b10, 32'h6});
    repeat (4) @(posedge core_clk);
    end_of_test();
  end
endmodule
